/* File: hdl/csi_core.sv */
// Purpose: Data memory access, accumulator, status flags and interrupt control.
// Assumes: Sequencer issues one memory access and one ALU op per cycle.
// Notes: Bank 1 holds only general locations; the shared area is bank 0.
//
// Overview of operation
// - Indirect location 00h uses pointer 0, location 02h uses pointer 1.
// - Indirect location reached through a pointer reads zero, write ignored.
// - Pointer 0 accesses always go to bank 0.
// - Pointer 1 accesses go to the bank chosen by bank select.
// - Accumulator sits at 05h; memory to memory moves go through it.
// - Status bit 0 is carry: add carry, subtract no borrow, rotates.
// - Status bit 1 is half carry from the low nibble.
// - Status bit 2 is zero flag for arithmetic and logic results.
// - Status bit 3 is overflow: carry into top bit differs from out.
// - Power-down flag set by halt, cleared by reset or watchdog clear.
// - Time-out flag set by timeout, cleared by reset, watchdog clear, halt.
// - Software status writes change arithmetic flags only.
// - Interrupt entry and calls do not save the status register.
// - Servicing an interrupt clears the master enable.
// - Requests while blocked are recorded but not acknowledged.
// - Nesting allowed once software re-enables master; source enables stay set.
// - No acknowledge while the return stack is full.
// - Acknowledge pushes only the program counter, then branches to vector.
// - Every interrupt source wakes the halted device.
// - Control bit 0 master enable, bit 1 bus enable, bit 3 timer enable.
// - Control bit 4 bus request, bit 6 timer request.
// - Bus interrupt vectors to 04h, timer to 0ch.
// - Bus interrupt wins over timer when both pending.
// - Acknowledge clears the served request and master enable.
// - Return from interrupt sets master enable; plain return does not.
`include "csi_params.svh"
`timescale 1ns/1ns
`default_nettype none
module csi_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  input wire logic accLoad,
  input wire logic [7:0] accWdata,
  input wire csi_pkg::csi_alu_op_e aluOp,
  input wire logic [7:0] aluOperand,
  input wire logic aluToAcc,
  output logic [7:0] aluResult,
  input wire csi_pkg::csi_seq_s seqEvent,
  input wire logic busIrqEvent,
  input wire logic timerIrqEvent,
  input wire logic stackFull,
  input wire logic irqTaken,
  output logic irqPending,
  output logic [10:0] irqVector,
  output logic wakeUp,
  output logic [7:0] accumulator,
  output logic [7:0] statusFlags,
  output logic [7:0] interruptControl
);
  logic [7:0] bank0Mem [0:127];
  logic [7:0] bank1Mem [0:127];
  logic [7:0] memoryPointer0_reg;
  logic [7:0] memoryPointer1_reg;
  logic bankSelect_reg;
  logic [7:0] accumulator_reg;
  logic [5:0] status_reg;
  logic [3:0] arithFlags_reg;
  logic powerDown_reg;
  logic timeout_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] effAddr;
  logic effBank;
  logic viaPointer;
  logic indirectLoop;
  logic generalSpace;
  csi_pkg::csi_alu_s alu;
  logic [8:0] wideSum;
  logic [4:0] nibbleSum;
  logic [7:0] carryIntoTop;
  logic carryIn;
  logic busService;
  logic tmrService;
  logic swIntcWrite;
  logic swStatusWrite;
  logic aluUpdatesFlags;

  // Resolve indirect locations to their pointer and bank.
  always_comb begin
    viaPointer = 1'b0;
    effAddr = memAddr;
    effBank = 1'b0;
    if (memAddr == `CSI_ADDR_IND0) begin
      viaPointer = 1'b1;
      effAddr = memoryPointer0_reg;
      effBank = 1'b0;
    end else if (memAddr == `CSI_ADDR_IND1) begin
      viaPointer = 1'b1;
      effAddr = memoryPointer1_reg;
      effBank = bankSelect_reg;
    end
  end

  // A pointer that names an indirect location itself yields nothing.
  assign indirectLoop = viaPointer &&
    (effAddr == `CSI_ADDR_IND0 || effAddr == `CSI_ADDR_IND1);
  assign generalSpace = effAddr > `CSI_SPECIAL_TOP;
  assign swIntcWrite = memWrite && !indirectLoop && effAddr == `CSI_ADDR_INTERRUPT_CONTROL;
  assign swStatusWrite = memWrite && !indirectLoop && effAddr == `CSI_ADDR_STATUS;

  always_comb begin
    memRdata = `CSI_RESET_BYTE;
    if (memRead && !indirectLoop) begin
      if (generalSpace) begin
        memRdata = effBank ? bank1Mem[effAddr[6:0]] : bank0Mem[effAddr[6:0]];
      end else begin
        unique case (effAddr)
          `CSI_ADDR_PTR0: memRdata = memoryPointer0_reg;
          `CSI_ADDR_PTR1: memRdata = memoryPointer1_reg;
          `CSI_ADDR_BANK: memRdata = {7'h00, bankSelect_reg};
          `CSI_ADDR_ACC: memRdata = accumulator_reg;
          `CSI_ADDR_STATUS: memRdata = {2'h0, status_reg};
          `CSI_ADDR_INTERRUPT_CONTROL: memRdata = interrupt_control_reg;
          default: memRdata = `CSI_RESET_BYTE;
        endcase
      end
    end
  end

  // General memory has no reset; software initialises it.
  always_ff @(posedge clk) begin
    if (memWrite && !indirectLoop && generalSpace) begin
      if (effBank) begin
        bank1Mem[effAddr[6:0]] <= memWdata;
      end else begin
        bank0Mem[effAddr[6:0]] <= memWdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      memoryPointer0_reg <= `CSI_RESET_BYTE;
      memoryPointer1_reg <= `CSI_RESET_BYTE;
      bankSelect_reg <= 1'b0;
    end else if (memWrite && !indirectLoop) begin
      if (effAddr == `CSI_ADDR_PTR0) begin
        memoryPointer0_reg <= memWdata;
      end
      if (effAddr == `CSI_ADDR_PTR1) begin
        memoryPointer1_reg <= memWdata;
      end
      if (effAddr == `CSI_ADDR_BANK) begin
        bankSelect_reg <= memWdata[0];
      end
    end
  end

  // ALU and its flags.
  always_comb begin
    carryIn = 1'b0;
    wideSum = 9'h000;
    nibbleSum = 5'h00;
    carryIntoTop = 8'h00;
    alu = '0;
    unique case (aluOp)
      csi_pkg::CSI_ALU_ADD, csi_pkg::CSI_ALU_ADC: begin
        carryIn = (aluOp == csi_pkg::CSI_ALU_ADC) ? status_reg[`CSI_ST_C] : 1'b0;
        wideSum = {1'b0, accumulator_reg} + {1'b0, aluOperand} + {8'h00, carryIn};
        nibbleSum = {1'b0, accumulator_reg[3:0]} + {1'b0, aluOperand[3:0]} + {4'h0, carryIn};
        carryIntoTop = {1'b0, accumulator_reg[6:0]} + {1'b0, aluOperand[6:0]} + {7'h00, carryIn};
      end
      csi_pkg::CSI_ALU_SUB, csi_pkg::CSI_ALU_SBC: begin
        // Subtract as add of the complement; carry out means no borrow.
        carryIn = (aluOp == csi_pkg::CSI_ALU_SBC) ? status_reg[`CSI_ST_C] : 1'b1;
        wideSum = {1'b0, accumulator_reg} + {1'b0, ~aluOperand} + {8'h00, carryIn};
        nibbleSum = {1'b0, accumulator_reg[3:0]} + {1'b0, ~aluOperand[3:0]} + {4'h0, carryIn};
        carryIntoTop = {1'b0, accumulator_reg[6:0]} + {1'b0, ~aluOperand[6:0]} + {7'h00, carryIn};
      end
      default: begin
      end
    endcase
    alu.result = wideSum[7:0];
    alu.carry = wideSum[8];
    alu.halfCarry = nibbleSum[4];
    alu.overflow = carryIntoTop[7] ^ wideSum[8];
    unique case (aluOp)
      csi_pkg::CSI_ALU_AND: alu.result = accumulator_reg & aluOperand;
      csi_pkg::CSI_ALU_OR: alu.result = accumulator_reg | aluOperand;
      csi_pkg::CSI_ALU_XOR: alu.result = accumulator_reg ^ aluOperand;
      csi_pkg::CSI_ALU_RLC: begin
        alu.result = {aluOperand[6:0], status_reg[`CSI_ST_C]};
        alu.carry = aluOperand[7];
      end
      csi_pkg::CSI_ALU_RRC: begin
        alu.result = {status_reg[`CSI_ST_C], aluOperand[7:1]};
        alu.carry = aluOperand[0];
      end
      default: begin
      end
    endcase
    alu.zero = (alu.result == 8'h00);
  end

  assign aluUpdatesFlags = (aluOp != csi_pkg::CSI_ALU_NONE);
  assign aluResult = alu.result;

  // Moves between memory locations pass through this register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accumulator_reg <= `CSI_RESET_BYTE;
    end else if (aluToAcc && aluUpdatesFlags) begin
      accumulator_reg <= alu.result;
    end else if (accLoad) begin
      accumulator_reg <= accWdata;
    end else if (memWrite && !indirectLoop && effAddr == `CSI_ADDR_ACC) begin
      accumulator_reg <= memWdata;
    end
  end

  // Each flag group has its own register so that one process drives each.
  assign status_reg = {timeout_reg, powerDown_reg, arithFlags_reg};

  // Arithmetic flags: the ALU wins over a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arithFlags_reg <= 4'h0;
    end else if (aluUpdatesFlags) begin
      arithFlags_reg[`CSI_ST_Z] <= alu.zero;
      if (aluOp inside {csi_pkg::CSI_ALU_ADD, csi_pkg::CSI_ALU_ADC,
                        csi_pkg::CSI_ALU_SUB, csi_pkg::CSI_ALU_SBC}) begin
        arithFlags_reg[`CSI_ST_C] <= alu.carry;
        arithFlags_reg[`CSI_ST_AC] <= alu.halfCarry;
        arithFlags_reg[`CSI_ST_OV] <= alu.overflow;
      end else if (aluOp inside {csi_pkg::CSI_ALU_RLC, csi_pkg::CSI_ALU_RRC}) begin
        arithFlags_reg[`CSI_ST_C] <= alu.carry;
      end
    end else if (swStatusWrite) begin
      arithFlags_reg <= memWdata[3:0];
    end
  end

  // Power-down and time-out flags ignore software writes entirely.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      powerDown_reg <= 1'b0;
    end else if (seqEvent.halt) begin
      powerDown_reg <= 1'b1;
    end else if (seqEvent.watchdogClear) begin
      powerDown_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timeout_reg <= 1'b0;
    end else if (seqEvent.watchdogTimeout) begin
      timeout_reg <= 1'b1;
    end else if (seqEvent.watchdogClear || seqEvent.halt) begin
      timeout_reg <= 1'b0;
    end
  end

  // Interrupt arbitration; the stack is the sequencer's, which pushes only the PC.
  assign busService = interrupt_control_reg[`CSI_IC_EMI] && interrupt_control_reg[`CSI_IC_EBUS] &&
    interrupt_control_reg[`CSI_IC_RBUS];
  assign tmrService = interrupt_control_reg[`CSI_IC_EMI] && interrupt_control_reg[`CSI_IC_ETMR] &&
    interrupt_control_reg[`CSI_IC_RTMR] && !busService;
  assign irqPending = (busService || tmrService) && !stackFull;
  assign irqVector = busService ? `CSI_VEC_BUS : `CSI_VEC_TMR;
  assign wakeUp = interrupt_control_reg[`CSI_IC_RBUS] || interrupt_control_reg[`CSI_IC_RTMR] ||
    busIrqEvent || timerIrqEvent;

  // Request flags: a new event wins over acknowledge or software clear.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_control_reg <= `CSI_RESET_BYTE;
    end else begin
      if (swIntcWrite) begin
        interrupt_control_reg <= memWdata & `CSI_IC_RW_MASK;
      end
      if (irqTaken && irqPending) begin
        interrupt_control_reg[`CSI_IC_EMI] <= 1'b0;
        if (busService) begin
          interrupt_control_reg[`CSI_IC_RBUS] <= 1'b0;
        end else begin
          interrupt_control_reg[`CSI_IC_RTMR] <= 1'b0;
        end
      end else if (seqEvent.returnFromIrq) begin
        interrupt_control_reg[`CSI_IC_EMI] <= 1'b1;
      end
      if (busIrqEvent) begin
        interrupt_control_reg[`CSI_IC_RBUS] <= 1'b1;
      end
      if (timerIrqEvent) begin
        interrupt_control_reg[`CSI_IC_RTMR] <= 1'b1;
      end
    end
  end

  // Status is not pushed on entry; software saves it if needed.
  assign accumulator = accumulator_reg;
  assign statusFlags = {2'h0, status_reg};
  assign interruptControl = interrupt_control_reg;
endmodule
`default_nettype wire

/* File: hdl/csi_params.svh */
// Purpose: Constants for the core status and interrupt control block.
// Assumes: Included by its bare name from the design file.
// Notes: Offsets are data memory addresses of the register file.
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH
`define CSI_ADDR_IND0 8'h00
`define CSI_ADDR_PTR0 8'h01
`define CSI_ADDR_IND1 8'h02
`define CSI_ADDR_PTR1 8'h03
`define CSI_ADDR_BANK 8'h04
`define CSI_ADDR_ACC 8'h05
`define CSI_ADDR_STATUS 8'h0a
`define CSI_ADDR_INTERRUPT_CONTROL 8'h0b
`define CSI_SPECIAL_TOP 8'h1f
`define CSI_ST_C 0
`define CSI_ST_AC 1
`define CSI_ST_Z 2
`define CSI_ST_OV 3
`define CSI_ST_PDF 4
`define CSI_ST_TO 5
`define CSI_ST_SW_MASK 8'h0f
`define CSI_IC_EMI 0
`define CSI_IC_EBUS 1
`define CSI_IC_ETMR 3
`define CSI_IC_RBUS 4
`define CSI_IC_RTMR 6
`define CSI_IC_RW_MASK 8'h5b
`define CSI_VEC_BUS 11'h004
`define CSI_VEC_TMR 11'h00c
`define CSI_RESET_BYTE 8'h00
`endif

/* File: hdl/csi_pkg.sv */
// Purpose: Types for the core status and interrupt control block.
// Assumes: Constants live in csi_params.svh.
// Notes: None.
package csi_pkg;
  typedef enum logic [3:0] {
    CSI_ALU_NONE, CSI_ALU_ADD, CSI_ALU_ADC, CSI_ALU_SUB, CSI_ALU_SBC,
    CSI_ALU_AND, CSI_ALU_OR, CSI_ALU_XOR, CSI_ALU_RLC, CSI_ALU_RRC
  } csi_alu_op_e;
  typedef struct packed {
    logic halt;
    logic watchdogClear;
    logic watchdogTimeout;
    logic returnPlain;
    logic returnFromIrq;
  } csi_seq_s;
  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic halfCarry;
    logic zero;
    logic overflow;
  } csi_alu_s;
endpackage

/* File: tb/csi_core_sva.sv */
// Purpose: Checker for the interrupt and status flag behaviour of csi_core.
// Assumes: Bound to csi_core from the testbench top file.
// Notes: Software writes at the acknowledge edge are excluded from the ack checks.
`timescale 1ns/1ns
`default_nettype none
module csi_core_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic memWrite,
  input wire csi_pkg::csi_seq_s seqEvent,
  input wire logic busIrqEvent,
  input wire logic stackFull,
  input wire logic irqTaken,
  input wire logic irqPending,
  input wire logic [10:0] irqVector,
  input wire logic wakeUp,
  input wire logic [7:0] statusFlags,
  input wire logic [7:0] interruptControl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_ack;
    irqTaken && irqPending && !memWrite && !seqEvent.returnFromIrq;
  endsequence
  sequence s_bus_sel;
    interruptControl[4] && interruptControl[1];
  endsequence
  a_ack_clears_emi: assert property (s_ack |=> !interruptControl[0])
    else $error("master enable survived acknowledge");
  a_ack_clears_flag: assert property (s_ack ##0 s_bus_sel ##0 !busIrqEvent
    |=> !interruptControl[4])
    else $error("served bus request flag not cleared");
  a_full_blocks: assert property (stackFull |-> !irqPending)
    else $error("pending shown while stack full");
  a_emi_blocks: assert property (!interruptControl[0] |-> !irqPending)
    else $error("pending shown while master disabled");
  a_bus_vector: assert property (irqPending ##0 s_bus_sel |-> irqVector == 11'h004)
    else $error("bus vector wrong");
  a_tmr_vector: assert property (irqPending && !(interruptControl[4] && interruptControl[1])
    |-> irqVector == 11'h00c)
    else $error("timer vector wrong");
  a_return_from_irq_sets_emi: assert property (seqEvent.returnFromIrq && !memWrite && !irqTaken
    |=> interruptControl[0])
    else $error("return from irq left master disabled");
  a_halt_flags: assert property (seqEvent.halt && !seqEvent.watchdogTimeout
    |=> statusFlags[5:4] == 2'b01)
    else $error("halt flags wrong");
  a_flags_hold: assert property (!(seqEvent.halt || seqEvent.watchdogClear
    || seqEvent.watchdogTimeout) |=> $stable(statusFlags[5:4]))
    else $error("power flags changed without cause");
  a_wake_request: assert property ((interruptControl[4] || interruptControl[6])
    |-> wakeUp)
    else $error("no wake with request pending");
endmodule
`default_nettype wire

/* File: tb/csi_seq_model.sv */
// Purpose: Sequencer model that acknowledges interrupts and records vectors.
// Assumes: holdOff models a sequencer that is busy and acknowledges late.
// Notes: Acknowledge is raised only while the core shows a pending request.
`timescale 1ns/1ns
`default_nettype none
module csi_seq_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic holdOff,
  input wire logic irqPending,
  input wire logic [10:0] irqVector,
  output logic irqTaken,
  output logic [10:0] lastVector
);
  assign irqTaken = irqPending && !holdOff;
  // The branch target is taken at the acknowledge edge, as a sequencer would.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lastVector <= 11'h7ff;
    end else if (irqTaken) begin
      lastVector <= irqVector;
    end
  end
endmodule
`default_nettype wire

/* File: tb/csi_core_tb_top.sv */
// Purpose: Self-checking testbench for csi_core.
// Assumes: Rows are {write, address, data, expected read} bytes.
// Notes: Two clocks per step; checks run at the falling edge.
`include "csi_params.svh"
`timescale 1ns/1ns
`default_nettype none
module csi_core_tb_top;
  logic clk, reset_n, memRead, memWrite, accLoad, aluToAcc, busIrqEvent, timerIrqEvent;
  logic stackFull, irqTaken, irqPending, wakeUp, holdOff;
  logic [7:0] memAddr, memWdata, memRdata, accWdata, aluOperand, aluResult;
  logic [7:0] accumulator, statusFlags, interruptControl;
  logic [10:0] irqVector, lastVector;
  csi_pkg::csi_alu_op_e aluOp;
  csi_pkg::csi_seq_s seqEvent;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] rows [24] = '{32'h01_01_40_00, 32'h01_00_55_00, 32'h00_00_00_55,
    32'h00_40_00_55, 32'h01_04_01_00, 32'h00_00_00_55, 32'h01_03_40_00, 32'h01_02_66_00,
    32'h00_02_00_66, 32'h01_04_00_00, 32'h00_02_00_55, 32'h01_01_02_00, 32'h00_00_00_00,
    32'h01_00_99_00, 32'h00_02_00_55, 32'h01_05_a5_00, 32'h00_05_00_a5, 32'h01_0a_ff_00,
    32'h00_0a_00_0f, 32'h01_0b_ff_00, 32'h00_0b_00_5b, 32'h01_0b_00_00, 32'h00_06_00_00,
    32'h01_05_7f_00};
  csi_core csi_core_inst (.clk, .reset_n, .memRead, .memWrite, .memAddr, .memWdata,
    .memRdata, .accLoad, .accWdata, .aluOp, .aluOperand, .aluToAcc, .aluResult, .seqEvent,
    .busIrqEvent, .timerIrqEvent, .stackFull, .irqTaken, .irqPending, .irqVector, .wakeUp,
    .accumulator, .statusFlags, .interruptControl);
  csi_seq_model csi_seq_model_inst (.clk, .reset_n, .holdOff, .irqPending, .irqVector,
    .irqTaken, .lastVector);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic mem(input logic [31:0] r);
    @(posedge clk);
    memWrite <= r[24];
    memRead <= !r[24];
    memAddr <= r[23:16];
    memWdata <= r[15:8];
    @(negedge clk);
    if (!r[24]) chk(memRdata, r[7:0]);
    @(posedge clk);
    memWrite <= 1'b0;
    memRead <= 1'b0;
  endtask
  task automatic alu(input csi_pkg::csi_alu_op_e op, input logic [7:0] b,
    input logic [7:0] ea, input logic [3:0] ef);
    @(posedge clk);
    aluOp <= op;
    aluOperand <= b;
    aluToAcc <= 1'b1;
    @(posedge clk);
    aluOp <= csi_pkg::CSI_ALU_NONE;
    aluToAcc <= 1'b0;
    @(negedge clk);
    chk(accumulator, ea);
    chk(statusFlags[3:0], ef);
  endtask
  task automatic ev(input logic [6:0] e);
    @(posedge clk);
    seqEvent <= csi_pkg::csi_seq_s'(e[4:0]);
    busIrqEvent <= e[5];
    timerIrqEvent <= e[6];
    @(posedge clk);
    seqEvent <= '0;
    busIrqEvent <= 1'b0;
    timerIrqEvent <= 1'b0;
    @(negedge clk);
  endtask
  task automatic ack(input logic [7:0] ec, input logic [10:0] ev);
    @(posedge clk);
    holdOff <= 1'b0;
    @(posedge clk);
    holdOff <= 1'b1;
    @(negedge clk);
    chk(interruptControl, ec);
    chk(lastVector, ev);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
  initial begin
    {reset_n, memRead, memWrite, accLoad, aluToAcc, busIrqEvent, timerIrqEvent} = '0;
    {memAddr, memWdata, accWdata, aluOperand} = '0;
    {stackFull, holdOff} = 2'b01;
    aluOp = csi_pkg::CSI_ALU_NONE;
    seqEvent = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk({statusFlags, interruptControl}, 16'h0000);
    chk(accumulator, 8'h00);
    $display("test reset done");
    foreach (rows[i]) mem(rows[i]);
    $display("test memory done");
    alu(csi_pkg::CSI_ALU_ADD, 8'h01, 8'h80, 4'ha);
    alu(csi_pkg::CSI_ALU_ADD, 8'h80, 8'h00, 4'hd);
    alu(csi_pkg::CSI_ALU_SUB, 8'h00, 8'h00, 4'h7);
    $display("test alu done");
    ev(7'h10);
    chk(statusFlags[5:4], 2'b01);
    ev(7'h04);
    chk(statusFlags[5:4], 2'b11);
    ev(7'h08);
    chk(statusFlags[5:4], 2'b00);
    $display("test power flags done");
    stackFull <= 1'b1;
    mem(32'h01_0b_0b_00);
    ev(7'h60);
    chk(interruptControl, 8'h5b);
    chk(irqPending, 1'b0);
    stackFull <= 1'b0;
    @(negedge clk);
    chk(irqVector, 11'h004);
    ack(8'h4a, 11'h004);
    chk({irqPending, wakeUp}, 2'b01);
    ev(7'h01);
    chk(interruptControl, 8'h4b);
    ack(8'h0a, 11'h00c);
    ev(7'h02);
    chk(interruptControl[0], 1'b0);
    ev(7'h40);
    mem(32'h01_0b_49_00);
    ack(8'h08, 11'h00c);
    $display("test interrupts done");
    conclude();
  end
endmodule
bind csi_core csi_core_sva csi_core_sva_inst (.clk, .reset_n, .memWrite, .seqEvent,
  .busIrqEvent, .stackFull, .irqTaken, .irqPending, .irqVector, .wakeUp, .statusFlags,
  .interruptControl);
`default_nettype wire
